// [rtl/csf_status.sv]
/*
  Status flag register, accumulator and system flags of the core,
  with an AXI4-Lite register port.
  Assumes the execution unit and watchdog run on aclk; the watchdog
  timeout and instruction strobes are one-cycle pulses of that clock.
*/
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "csf_defines.svh"

module csf_status
  import csf_pkg::*;
(
  input  wire logic              aclk,          // Core clock
  input  wire logic              aresetn,       // Power-on reset, low
  input  wire csf_pkg::csf_req_t req,           // ALU request
  input  wire logic              wdclr_instr,   // Watchdog clear pulse
  input  wire logic              stop_instr,    // Stop instruction pulse
  input  wire logic              wdt_timeout,   // Watchdog timeout pulse
  output var  logic [7:0]        status_flags,  // Status byte
  output var  logic [7:0]        acc,           // Accumulator
  input  wire logic [11:0]       s_awaddr,      // Write address
  input  wire logic [2:0]        s_awprot,      // Unused protection
  input  wire logic              s_awvalid,     // Write address valid
  output var  logic              s_awready,     // Write address ready
  input  wire logic [31:0]       s_wdata,       // Write data
  input  wire logic [3:0]        s_wstrb,       // Byte strobes
  input  wire logic              s_wvalid,      // Write data valid
  output var  logic              s_wready,      // Write data ready
  output var  logic [1:0]        s_bresp,       // Write response
  output var  logic              s_bvalid,      // Write response valid
  input  wire logic              s_bready,      // Write response ready
  input  wire logic [11:0]       s_araddr,      // Read address
  input  wire logic [2:0]        s_arprot,      // Unused protection
  input  wire logic              s_arvalid,     // Read address valid
  output var  logic              s_arready,     // Read address ready
  output var  logic [31:0]       s_rdata,       // Read data
  output var  logic [1:0]        s_rresp,       // Read response
  output var  logic              s_rvalid,      // Read response valid
  input  wire logic              s_rready       // Read response ready
);

  //--------------------------------------------------------------------
  // Bus front end
  //--------------------------------------------------------------------
  logic        wr_en;    // Commit strobe
  logic [11:0] wr_addr;  // Commit address
  logic [7:0]  wr_data;  // Commit byte
  logic        wr_ok;    // Write address mapped
  logic [11:0] rd_addr;  // Read address
  logic [7:0]  rd_data;  // Read byte
  logic        rd_ok;    // Read address mapped
  logic        prot_unused;  // Protection bits carry no meaning here

  assign prot_unused = ^{s_awprot, s_arprot};

  csf_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_awaddr),
    .awvalid (s_awvalid),
    .awready (s_awready),
    .wdata   (s_wdata),
    .wstrb   (s_wstrb),
    .wvalid  (s_wvalid),
    .wready  (s_wready),
    .bresp   (s_bresp),
    .bvalid  (s_bvalid),
    .bready  (s_bready),
    .araddr  (s_araddr),
    .arvalid (s_arvalid),
    .arready (s_arready),
    .rdata   (s_rdata),
    .rresp   (s_rresp),
    .rvalid  (s_rvalid),
    .rready  (s_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // Address decode
  always_comb begin
    wr_ok = (wr_addr == `CSF_ADDR_STATUS) || (wr_addr == `CSF_ADDR_ACC) ||
            (wr_addr == `CSF_ADDR_CTRL);
    rd_ok = 1'b1;
    unique case (rd_addr)
      `CSF_ADDR_STATUS: rd_data = status_flags;
      `CSF_ADDR_ACC:    rd_data = acc;
      `CSF_ADDR_CTRL:   rd_data = 8'h00;  // Pulse bits read as zero
      default: begin
        rd_data = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  //--------------------------------------------------------------------
  // ALU
  //--------------------------------------------------------------------
  csf_alu_t alu;  // Result and flags of the current request

  csf_alu u_alu (
    .op    (req.op),
    .a     (acc),
    .b     (req.opnd),
    .c_in  (status_flags[`CSF_BIT_C]),
    .cz_in (status_flags[`CSF_BIT_CZ]),
    .out   (alu)
  );

  //--------------------------------------------------------------------
  // Flag and accumulator update
  //--------------------------------------------------------------------
  logic [7:0] next_status_flags;  // Next status byte
  logic [7:0] next_acc;           // Next accumulator
  logic       bus_wdclr;          // Software watchdog clear
  logic       bus_stop;           // Software stop
  logic       bus_tmo;            // Software timeout, for test use
  logic       do_op;              // A real ALU operation arrives

  // Call and interrupt entry touch nothing here: saving is software's
  // job, so no stack path exists.
  always_comb begin
    bus_wdclr = wr_en && (wr_addr == `CSF_ADDR_CTRL) &&
                wr_data[`CSF_CTRL_WDCLR];
    bus_stop  = wr_en && (wr_addr == `CSF_ADDR_CTRL) &&
                wr_data[`CSF_CTRL_STOP];
    bus_tmo   = wr_en && (wr_addr == `CSF_ADDR_CTRL) &&
                wr_data[`CSF_CTRL_TMO];
    do_op     = req.valid && (req.op != CSF_OP_NONE);
    next_status_flags = status_flags;
    next_acc          = acc;
    // Status register writes reach only the arithmetic bits
    if (wr_en && (wr_addr == `CSF_ADDR_STATUS)) begin
      next_status_flags = (status_flags & ~`CSF_WR_MASK) |
                          (wr_data & `CSF_WR_MASK);
    end
    if (wr_en && (wr_addr == `CSF_ADDR_ACC)) begin
      next_acc = wr_data;
    end
    // An ALU result wins over a bus write in the same cycle
    if (do_op) begin
      next_acc                     = alu.res;
      next_status_flags[`CSF_BIT_SC] = alu.sc;
      next_status_flags[`CSF_BIT_CZ] = alu.cz;
      next_status_flags[`CSF_BIT_OV] = alu.ov;
      next_status_flags[`CSF_BIT_Z]  = alu.z;
      next_status_flags[`CSF_BIT_AC] = alu.ac;
      next_status_flags[`CSF_BIT_C]  = alu.c;
    end
    // System flags: clear first, set wins over clear
    if (wdclr_instr || bus_wdclr) begin
      next_status_flags[`CSF_BIT_PD] = 1'b0;
      next_status_flags[`CSF_BIT_TO] = 1'b0;
    end
    if (stop_instr || bus_stop) begin
      next_status_flags[`CSF_BIT_TO] = 1'b0;
      next_status_flags[`CSF_BIT_PD] = 1'b1;
    end
    if (wdt_timeout || bus_tmo) begin
      next_status_flags[`CSF_BIT_TO] = 1'b1;
    end
  end

  // Register stage; bit layout fixed by the BIT macros
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_flags <= `CSF_STATUS_RESET;
      acc          <= `CSF_ACC_RESET;
    end else begin
      status_flags <= next_status_flags ^ {7'h00, 1'b0 & prot_unused};
      acc          <= next_acc;
    end
  end

endmodule
`default_nettype wire

// [rtl/csf_defines.svh]
/*
  Constants of the status flag block: register offsets, bit positions,
  reset values, control bits and bus responses.
  Assumes inclusion by bare name from the modules and the bench.
*/
//----------------------------------------------------------------------
// Function
//----------------------------------------------------------------------
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH

// Register byte addresses on the bus
`define CSF_ADDR_STATUS   12'h000
`define CSF_ADDR_ACC      12'h004
`define CSF_ADDR_CTRL     12'h008

// Status byte bit positions
`define CSF_BIT_SC        7
`define CSF_BIT_CZ        6
`define CSF_BIT_TO        5
`define CSF_BIT_PD        4
`define CSF_BIT_OV        3
`define CSF_BIT_Z         2
`define CSF_BIT_AC        1
`define CSF_BIT_C         0

// Bits of the status byte a write to the status register may change
`define CSF_WR_MASK       8'hcf
`define CSF_STATUS_RESET  8'h00
`define CSF_ACC_RESET     8'h00

// Control register bits (write one to pulse)
`define CSF_CTRL_WDCLR    0
`define CSF_CTRL_STOP     1
`define CSF_CTRL_TMO      2

// AXI responses
`define CSF_RESP_OKAY     2'b00
`define CSF_RESP_SLVERR   2'b10

`endif

// [rtl/csf_pkg.sv]
/*
  Types of the status flag block: ALU operation codes and flag record.
  Assumes csf_defines.svh is on the include path.
*/
package csf_pkg;

  // ALU operations offered by the execution unit
  typedef enum logic [3:0] {
    CSF_OP_NONE = 4'h0,  // No operation
    CSF_OP_ADD  = 4'h1,  // Add
    CSF_OP_ADC  = 4'h2,  // Add with carry
    CSF_OP_SUB  = 4'h3,  // Plain subtract
    CSF_OP_SBC  = 4'h4,  // Subtract with borrow
    CSF_OP_AND  = 4'h5,  // Logical and
    CSF_OP_OR   = 4'h6,  // Logical or
    CSF_OP_XOR  = 4'h7,  // Logical xor
    CSF_OP_RLC  = 4'h8,  // Rotate left through carry
    CSF_OP_RRC  = 4'h9,  // Rotate right through carry
    CSF_OP_MOV  = 4'ha   // Load accumulator from operand
  } csf_op_t;

  // Request from the execution unit
  typedef struct packed {
    logic       valid;  // One-cycle strobe
    csf_op_t    op;     // Operation
    logic [7:0] opnd;   // Second operand (first is accumulator)
  } csf_req_t;

  // Flags produced by one ALU operation
  typedef struct packed {
    logic       sc;     // Signed compare
    logic       cz;     // Chained null
    logic       ov;     // Signed wrap
    logic       z;      // Zero
    logic       ac;     // Half carry
    logic       c;      // Carry
    logic [7:0] res;    // Result
  } csf_alu_t;

endpackage

// [rtl/csf_alu.sv]
/*
  Combinational 8-bit ALU with flag generation.
  Assumes the accumulator and current flags arrive from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csf_defines.svh"

module csf_alu
  import csf_pkg::*;
(
  input  wire csf_pkg::csf_op_t  op,     // Operation
  input  wire logic [7:0]        a,      // Accumulator
  input  wire logic [7:0]        b,      // Operand
  input  wire logic              c_in,   // Current carry
  input  wire logic              cz_in,  // Current chained null
  output var  csf_pkg::csf_alu_t out     // Result and flags
);

  //--------------------------------------------------------------------
  // Arithmetic
  //--------------------------------------------------------------------
  logic [8:0] sum;     // Nine-bit sum with carry out
  logic [4:0] lo;      // Low nibble sum
  logic [7:0] bb;      // Operand, inverted for subtract
  logic       cin;     // Carry into bit 0
  logic       c7;      // Carry into the MSB
  logic       arith;   // Operation is add or subtract

  // Subtract is a + ~b + 1, so carry out means no borrow
  always_comb begin
    bb    = b;
    cin   = 1'b0;
    arith = 1'b1;
    unique case (op)
      CSF_OP_ADD: cin = 1'b0;
      CSF_OP_ADC: cin = c_in;
      CSF_OP_SUB: begin
        bb  = ~b;
        cin = 1'b1;
      end
      CSF_OP_SBC: begin
        bb  = ~b;
        cin = c_in;
      end
      default:    arith = 1'b0;
    endcase
    sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
    lo  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    c7  = a[7] ^ bb[7] ^ sum[7];
  end

  //--------------------------------------------------------------------
  // Result and flags
  //--------------------------------------------------------------------
  // Logic operations keep carry unchanged upstream and clear half carry and wrap
  always_comb begin
    out     = '0;
    out.c   = c_in;
    out.cz  = cz_in;
    unique case (op)
      CSF_OP_AND: out.res = a & b;
      CSF_OP_OR:  out.res = a | b;
      CSF_OP_XOR: out.res = a ^ b;
      CSF_OP_MOV: out.res = b;
      CSF_OP_RLC: begin
        out.res = {a[6:0], c_in};
        out.c   = a[7];
      end
      CSF_OP_RRC: begin
        out.res = {c_in, a[7:1]};
        out.c   = a[0];
      end
      default:    out.res = sum[7:0];
    endcase
    if (arith) begin
      out.c  = sum[8];
      out.ac = lo[4];
      out.ov = c7 ^ sum[8];
    end
    out.z  = (out.res == 8'h00);
    out.sc = out.ov ^ out.res[7];
    if (op == CSF_OP_SUB)
      out.cz = out.z;
    else if (op == CSF_OP_SBC)
      out.cz = cz_in & out.z;
  end

endmodule
`default_nettype wire

// [rtl/csf_axil.sv]
/*
  AXI4-Lite slave front end: one write and one read at a time.
  Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csf_defines.svh"

module csf_axil (
  input  wire logic        aclk,     // Clock
  input  wire logic        aresetn,  // Reset, active low
  input  wire logic [11:0] awaddr,   // Write address
  input  wire logic        awvalid,  // Write address valid
  output var  logic        awready,  // Write address ready
  input  wire logic [31:0] wdata,    // Write data
  input  wire logic [3:0]  wstrb,    // Byte strobes
  input  wire logic        wvalid,   // Write data valid
  output var  logic        wready,   // Write data ready
  output var  logic [1:0]  bresp,    // Write response
  output var  logic        bvalid,   // Write response valid
  input  wire logic        bready,   // Write response ready
  input  wire logic [11:0] araddr,   // Read address
  input  wire logic        arvalid,  // Read address valid
  output var  logic        arready,  // Read address ready
  output var  logic [31:0] rdata,    // Read data
  output var  logic [1:0]  rresp,    // Read response
  output var  logic        rvalid,   // Read response valid
  input  wire logic        rready,   // Read response ready
  output var  logic        wr_en,    // Write strobe, one cycle
  output var  logic [11:0] wr_addr,  // Write address
  output var  logic [7:0]  wr_data,  // Write low byte
  input  wire logic        wr_ok,    // Write address mapped
  output var  logic [11:0] rd_addr,  // Read address
  input  wire logic [7:0]  rd_data,  // Read byte
  input  wire logic        rd_ok     // Read address mapped
);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  logic        aw_have, next_aw_have;  // Address captured
  logic        w_have,  next_w_have;   // Data captured
  logic [11:0] awa,     next_awa;      // Held write address
  logic [7:0]  wd,      next_wd;       // Held write byte
  logic        wd_lane, next_wd_lane;  // Low lane was strobed
  logic        next_awready, next_wready, next_bvalid, next_arready;
  logic        next_rvalid, next_wr_en;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // Ready is registered; it falls after each capture
  always_comb begin
    next_aw_have = aw_have;
    next_w_have  = w_have;
    next_awa     = awa;
    next_wd      = wd;
    next_wd_lane = wd_lane;
    next_awready = ~aw_have & ~bvalid;
    next_wready  = ~w_have & ~bvalid;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_wr_en   = 1'b0;
    next_arready = ~rvalid & ~arready;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid && awready) begin
      next_aw_have = 1'b1;
      next_awa     = awaddr;
      next_awready = 1'b0;
    end
    if (wvalid && wready) begin
      next_w_have  = 1'b1;
      next_wd      = wdata[7:0];
      next_wd_lane = wstrb[0];
      next_wready  = 1'b0;
    end
    // Both halves present: commit and answer
    if (aw_have && w_have && !bvalid) begin
      next_wr_en   = wd_lane;
      next_bvalid  = 1'b1;
      next_bresp   = wr_ok ? `CSF_RESP_OKAY : `CSF_RESP_SLVERR;
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = {24'h000000, rd_data};
      next_rresp   = rd_ok ? `CSF_RESP_OKAY : `CSF_RESP_SLVERR;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  assign rd_addr = araddr;
  assign wr_addr = awa;
  assign wr_data = wd;

  // Register stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      awa     <= 12'h000;
      wd      <= 8'h00;
      wd_lane <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `CSF_RESP_OKAY;
      wr_en   <= 1'b0;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `CSF_RESP_OKAY;
    end else begin
      aw_have <= next_aw_have;
      w_have  <= next_w_have;
      awa     <= next_awa;
      wd      <= next_wd;
      wd_lane <= next_wd_lane;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      wr_en   <= next_wr_en;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

endmodule
`default_nettype wire

// [bench/csf_status_asserts.sv]
/*
  Checker of the status flag block: flag arithmetic and system flags.
  Assumes binding onto csf_status, one clock, sync active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module csf_status_chk
  import csf_pkg::*;
(
  input wire logic              aclk,          // Core clock
  input wire logic              aresetn,       // Reset, low
  input wire csf_pkg::csf_req_t req,           // ALU request
  input wire logic              wdclr_instr,   // Watchdog clear
  input wire logic              stop_instr,    // Stop
  input wire logic              wdt_timeout,   // Watchdog timeout
  input wire logic [7:0]        status_flags,  // Status byte
  input wire logic [7:0]        acc            // Accumulator
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [8:0] sum_q;   // Add result and carry
  logic [8:0] dif_q;   // Subtract, top bit is no-borrow
  logic [4:0] nib_q;   // Low nibble add
  logic [7:0] low_q;   // Bit 7 is carry into the MSB
  logic       add_go;  // Add taken
  logic       sub_go;  // Plain subtract taken
  logic       sbc_go;  // Borrow subtract taken
  logic       any_go;  // Any real op taken
  assign add_go = req.valid && req.op == CSF_OP_ADD;
  assign sub_go = req.valid && req.op == CSF_OP_SUB;
  assign sbc_go = req.valid && req.op == CSF_OP_SBC;
  assign any_go = req.valid && req.op != CSF_OP_NONE;
  // Expected sums of acc and operand captured every edge, compared one cycle on
  always_ff @(posedge aclk) begin
    sum_q <= {1'b0, acc} + {1'b0, req.opnd};
    dif_q <= {1'b0, acc} + {1'b0, ~req.opnd} + 9'h001;
    nib_q <= {1'b0, acc[3:0]} + {1'b0, req.opnd[3:0]};
    low_q <= {1'b0, acc[6:0]} + {1'b0, req.opnd[6:0]};
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_add_result: assert property (add_go |=> {status_flags[0], acc} == sum_q)
    else $error("add result or carry wrong");
  a_sub_carry: assert property (sub_go |=> {status_flags[0], acc} == dif_q)
    else $error("subtract result or carry wrong");
  a_half_carry: assert property (add_go |=> status_flags[1] == nib_q[4])
    else $error("half carry wrong");
  a_zero_flag: assert property (any_go |=> status_flags[2] == (acc == 8'h00))
    else $error("zero flag wrong");
  a_signed_wrap: assert property (add_go |=> status_flags[3] == (low_q[7] ^ sum_q[8]))
    else $error("signed wrap wrong");
  a_signed_cmp: assert property (any_go |=> status_flags[7] == (status_flags[3] ^ acc[7]))
    else $error("signed compare wrong");
  a_chain_sub: assert property (sub_go |=> status_flags[6] == status_flags[2])
    else $error("chained null after subtract wrong");
  a_chain_sbc: assert property (sbc_go |=> status_flags[6] == ($past(status_flags[6]) & status_flags[2]))
    else $error("chained null after borrow subtract wrong");
  a_stop_halts: assert property (stop_instr && !wdt_timeout |=> status_flags[5:4] == 2'b01)
    else $error("stop did not set halted and clear expired");
  a_timeout_sets: assert property (wdt_timeout |=> status_flags[5])
    else $error("timeout did not set expired");
  a_clear_sys: assert property (wdclr_instr && !stop_instr && !wdt_timeout |=> status_flags[5:4] == 2'b00)
    else $error("watchdog clear left a system flag set");
  a_reset_zero: assert property (disable iff (1'b0) !aresetn |=> status_flags == 8'h00 && acc == 8'h00)
    else $error("reset values not zero");
  c_sbc: cover property (sbc_go);
  c_stop: cover property (stop_instr);
  c_tmo: cover property (wdt_timeout);
endmodule
bind csf_status csf_status_chk u_csf_status_chk (.aclk, .aresetn, .req, .wdclr_instr, .stop_instr, .wdt_timeout, .status_flags, .acc);
`default_nettype wire

// [bench/csf_exec_model.sv]
/*
  Execution unit model: issues ALU requests and system pulses.
  Assumes tasks are entered just after a rising edge of aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module csf_exec_model
  import csf_pkg::*;
(
  input  wire logic              aclk,         // Core clock
  output var  csf_pkg::csf_req_t req,          // ALU request
  output var  logic              wdclr_instr,  // Watchdog clear
  output var  logic              stop_instr,   // Stop
  output var  logic              wdt_timeout   // Watchdog timeout
);
  // Quiet at time zero
  initial begin
    req = '0;
    {wdclr_instr, stop_instr, wdt_timeout} = 3'b000;
  end
  // One op per call; strobe stays up so calls run back to back
  task automatic alu(input csf_op_t op, input logic [7:0] d);
    req <= '{valid: 1'b1, op: op, opnd: d};
    @(posedge aclk);
    #1;
  endtask
  // Drop strobe; operand inverted so stale data never looks valid
  task automatic idle();
    req <= '{valid: 1'b0, op: CSF_OP_NONE, opnd: ~req.opnd};
    @(posedge aclk);
    #1;
  endtask
  // One-cycle pulse of {clear, stop, timeout}, then one quiet cycle so
  // that a following call never drives the pulses twice in one step
  task automatic sys(input logic [2:0] k);
    {wdclr_instr, stop_instr, wdt_timeout} <= k;
    @(posedge aclk);
    #1;
    {wdclr_instr, stop_instr, wdt_timeout} <= 3'b000;
    @(posedge aclk);
    #1;
  endtask
endmodule
`default_nettype wire

// [bench/csf_status_test.sv]
/*
  Self-checking bench of the status flag block.
  Assumes the package, defines, design and model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "csf_defines.svh"
module csf_status_test;
  import csf_pkg::*;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
  logic s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic wdclr_instr, stop_instr, wdt_timeout;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic [2:0]  s_prot;  // Protection, must not change any answer
  logic [1:0]  s_bresp, s_rresp;
  logic [7:0]  status_flags, acc;
  csf_req_t    req;
  int          num_errors, n_checks, cyc, i;
  logic [27:0] tbl [14];  // {op, operand, acc, status}
  csf_status u_csf_status (.aclk, .aresetn, .req, .wdclr_instr,
    .stop_instr, .wdt_timeout, .status_flags, .acc, .s_awaddr,
    .s_awprot(s_prot), .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arprot(s_prot), .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready);
  csf_exec_model u_csf_exec_model (.aclk, .req, .wdclr_instr,
    .stop_instr, .wdt_timeout);
  // ----------------------------------------
  // Clock, watchdog on the run, report
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // A hang counts as a mismatch
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("%0d checks, %0d errors", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  // ----------------------------------------
  // Bus master tasks
  // ----------------------------------------
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int k;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    // Response ready stays high, so back-to-back calls never toggle it
    chk("bresp", {30'h0, er}, {30'h0, s_bresp});
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int k;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    chk("rdata", ed, s_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_rresp});
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_prot} = '0;
    s_wstrb = 4'hf;
    {num_errors, n_checks, cyc} = '0;
    tbl = '{28'ha7f7f00, 28'h101800a, 28'h180008d, 28'h3000047,
            28'h401ff80, 28'h4fe0007, 28'h3000047, 28'h0ff0047,
            28'h5000045, 28'h65a5a41, 28'h7ffa5c1, 28'h8004b41,
            28'h900a5c1, 28'h25a0047};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(`CSF_ADDR_STATUS, 32'h0, `CSF_RESP_OKAY);
    axi_rd(`CSF_ADDR_ACC, 32'h0, `CSF_RESP_OKAY);
    // Low lane not strobed: accepted but nothing written
    s_wstrb <= 4'he;
    s_prot  <= 3'h5;
    axi_wr(`CSF_ADDR_ACC, 32'h1ff, `CSF_RESP_OKAY);
    axi_rd(`CSF_ADDR_ACC, 32'h0, `CSF_RESP_OKAY);
    s_wstrb <= 4'hf;
    axi_wr(`CSF_ADDR_ACC, 32'h13c, `CSF_RESP_OKAY);
    axi_rd(`CSF_ADDR_ACC, 32'h3c, `CSF_RESP_OKAY);
    axi_wr(`CSF_ADDR_STATUS, 32'hff, `CSF_RESP_OKAY);
    axi_rd(`CSF_ADDR_STATUS, 32'hcf, `CSF_RESP_OKAY);
    axi_wr(`CSF_ADDR_STATUS, 32'h0, `CSF_RESP_OKAY);
    $display("test regs done");
    // Back-to-back ops, each checked right after it is taken
    for (i = 0; i < 14; i++) begin
      u_csf_exec_model.alu(csf_op_t'(tbl[i][27:24]), tbl[i][23:16]);
      chk("acc", {24'h0, tbl[i][15:8]}, {24'h0, acc});
      chk("status", {24'h0, tbl[i][7:0]}, {24'h0, status_flags});
    end
    u_csf_exec_model.idle();
    $display("test alu done");
    u_csf_exec_model.sys(3'b001);
    chk("sysflags", 32'h2, {30'h0, status_flags[5:4]});
    u_csf_exec_model.sys(3'b010);
    chk("sysflags", 32'h1, {30'h0, status_flags[5:4]});
    u_csf_exec_model.sys(3'b001);
    chk("sysflags", 32'h3, {30'h0, status_flags[5:4]});
    axi_wr(`CSF_ADDR_STATUS, 32'h0, `CSF_RESP_OKAY);
    axi_rd(`CSF_ADDR_STATUS, 32'h30, `CSF_RESP_OKAY);
    u_csf_exec_model.sys(3'b100);
    chk("sysflags", 32'h0, {30'h0, status_flags[5:4]});
    $display("test sys done");
    axi_wr(`CSF_ADDR_CTRL, 32'h4, `CSF_RESP_OKAY);
    axi_rd(`CSF_ADDR_STATUS, 32'h20, `CSF_RESP_OKAY);
    axi_wr(`CSF_ADDR_CTRL, 32'h2, `CSF_RESP_OKAY);
    axi_rd(`CSF_ADDR_STATUS, 32'h10, `CSF_RESP_OKAY);
    axi_rd(`CSF_ADDR_CTRL, 32'h0, `CSF_RESP_OKAY);
    axi_wr(12'h00c, 32'hff, `CSF_RESP_SLVERR);
    axi_rd(12'h00c, 32'h0, `CSF_RESP_SLVERR);
    $display("test bus done");
    // Reset in mid-run must clear the halted flag left set above
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(`CSF_ADDR_STATUS, 32'h0, `CSF_RESP_OKAY);
    $display("test reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
